// File: rtl/drc_device.sv
// Purpose: device end, reference calibration mode interpreter
// Assumes: one command per cycle on the link, synchronous reset
// Notes:   settle uses short wait for moves of at most one step, long otherwise
`timescale 1ns/1ps
`default_nettype none
module drc_device #(
  parameter int ENTRY_CYC = drc_pkg::ENTRY_WAIT_CYC,
  parameter int EXIT_CYC  = drc_pkg::EXIT_WAIT_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  drc_link_if.dev               link,
  output logic [6:0]            refSetting,
  output logic                  rangeSel,
  output logic                  calMode
);
  import drc_pkg::*;

  if (ENTRY_CYC < 1 || ENTRY_CYC > 255 || EXIT_CYC < 1 || EXIT_CYC > 255) begin : g_bad_wait
    $error("wait counts must be 1..255");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_CAL, ST_EXIT} drc_state_t;
  drc_state_t            state_r, state_nxt;
  logic [CNT_W-1:0]      cnt_r, cnt_nxt;
  logic [CNT_W-1:0]      settle_r, settle_nxt;
  logic [6:0]            setting_r, setting_nxt;
  logic                  err_r, err_nxt;
  logic                  openBank_r, openBank_nxt;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic       isMrs    = (link.cmd == CMD_MRS);
  wire logic       isDes    = (link.cmd == CMD_DES);
  wire logic       calBit   = link.mrData[CAL_EN_BIT];
  wire logic       newRange = link.mrData[RANGE_BIT];
  wire logic [5:0] newCode  = link.mrData[VALUE_MSB:0];
  wire logic       legalCal = (link.cmd != CMD_OTHER)
                              && (!link.pdaMode || isMrs || isDes);
  wire logic       rangeOk  = (newRange == setting_r[RANGE_BIT]);
  wire logic       codeOk   = (newCode < CODE_RSVD_MIN);
  wire logic [5:0] diff     = (newCode > setting_r[5:0]) ? newCode - setting_r[5:0]
                                                         : setting_r[5:0] - newCode;
  wire logic [CNT_W-1:0] settleLoad = (diff <= 6'h01) ? CNT_W'(SETTLE_SHORT_CYC)
                                                      : CNT_W'(SETTLE_LONG_CYC);

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    settle_nxt   = (settle_r != '0) ? settle_r - 1'b1 : settle_r;
    setting_nxt  = setting_r;
    err_nxt      = 1'b0;
    openBank_nxt = openBank_r;
    if (link.cmd == CMD_ACT) openBank_nxt = 1'b1;
    if (link.cmd == CMD_PRE) openBank_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (isMrs && calBit) begin
          setting_nxt[RANGE_BIT] = newRange;
          state_nxt = ST_ENTRY;
          cnt_nxt   = CNT_W'(ENTRY_CYC);
        end else if (isMrs) begin
          setting_nxt = link.mrData[SETTING_MSB:0];
        end
      end
      ST_ENTRY: begin
        if (!isDes) err_nxt = 1'b1;
        if (cnt_r <= 1) state_nxt = ST_CAL;
      end
      ST_CAL: begin
        if (!legalCal) err_nxt = 1'b1;
        if (isMrs && calBit) begin
          if (rangeOk && codeOk) begin
            setting_nxt[5:0] = newCode;
            settle_nxt = settleLoad;
          end else begin
            err_nxt = 1'b1;
          end
        end else if (isMrs) begin
          if (openBank_r || settle_r != '0) err_nxt = 1'b1;
          state_nxt = ST_EXIT;
          cnt_nxt   = CNT_W'(EXIT_CYC);
        end
        // dummy writes before first update need no special case
      end
      ST_EXIT: begin
        if (!isDes) err_nxt = 1'b1;
        if (cnt_r <= 1) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r    <= ST_IDLE;
      cnt_r      <= '0;
      settle_r   <= '0;
      setting_r  <= SETTING_RST;
      err_r      <= 1'b0;
      openBank_r <= 1'b0;
    end else if (clkEn) begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      settle_r   <= settle_nxt;
      setting_r  <= setting_nxt;
      err_r      <= err_nxt;
      openBank_r <= openBank_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign calMode         = (state_r != ST_IDLE);
  assign link.calActive  = calMode;
  assign link.levelValid = (settle_r == '0);
  assign link.cmdError   = err_r;
  assign refSetting      = setting_r;
  assign rangeSel        = setting_r[RANGE_BIT];
endmodule : drc_device
`default_nettype wire

// File: rtl/drc_pkg.sv
// Purpose: shared constants and types for reference calibration mode
// Assumes: one command clock, 100 MHz
// Notes:   waits are counted in clock cycles
`default_nettype none
package drc_pkg;
  // ----------------------------------------
  // command encoding
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_DES, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_RDA, CMD_PRE, CMD_MRS, CMD_OTHER
  } drc_cmd_t;

  // ----------------------------------------
  // register fields
  // ----------------------------------------
  localparam int  MR_WIDTH      = 8;
  localparam int  CAL_EN_BIT    = 7;
  localparam int  RANGE_BIT     = 6;
  localparam int  VALUE_MSB     = 5;
  localparam int  SETTING_MSB   = 6;
  localparam logic [6:0] SETTING_RST   = 7'h00;
  localparam logic [5:0] CODE_RSVD_MIN = 6'h33;

  // ----------------------------------------
  // timing, ns and derived cycles
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ENTRY_WAIT_NS  = 150;
  localparam int EXIT_WAIT_NS   = 150;
  localparam int SETTLE_SHORT_NS = 80;
  localparam int SETTLE_LONG_NS = 250;
  localparam int ENTRY_WAIT_CYC = (ENTRY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXIT_WAIT_CYC  = (EXIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_SHORT_CYC = (SETTLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_LONG_CYC = (SETTLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;
endpackage : drc_pkg
`default_nettype wire

// File: rtl/drc_link_if.sv
// Purpose: command link between controller and device
// Assumes: synchronous to sys_clk
// Notes:   no clocking block
`timescale 1ns/1ps
`default_nettype none
interface drc_link_if;
  import drc_pkg::*;
  drc_cmd_t                    cmd;
  logic     [MR_WIDTH-1:0]     mrData;
  logic                        pdaMode;
  logic                        calActive;
  logic                        levelValid;
  logic                        cmdError;
  modport dev  (input cmd, input mrData, input pdaMode,
                output calActive, output levelValid, output cmdError);
  modport host (output cmd, output mrData, output pdaMode,
                input calActive, input levelValid, input cmdError);
endinterface : drc_link_if
`default_nettype wire

// File: rtl/drc_host.sv
// Purpose: controller end, issues calibration sequences
// Assumes: device end on the same clock
// Notes:   user asks for enter, step, exit; host keeps waits
`timescale 1ns/1ps
`default_nettype none
module drc_host #(
  parameter int ENTRY_CYC = drc_pkg::ENTRY_WAIT_CYC,
  parameter int EXIT_CYC  = drc_pkg::EXIT_WAIT_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  input  wire logic             reqEnter,
  input  wire logic             reqRange,
  input  wire logic             reqSet,
  input  wire logic [5:0]       reqCode,
  input  wire logic             reqExit,
  input  wire logic             reqPda,
  output logic                  busy,
  output logic                  sawError,
  drc_link_if.host              link
);
  import drc_pkg::*;

  // exit wait is loaded two higher, so it must still fit the counter
  if (ENTRY_CYC < 1 || ENTRY_CYC > 255 || EXIT_CYC < 1 || EXIT_CYC > 253) begin : g_bad_wait
    $error("entry wait must be 1..255, exit wait 1..253");
  end

  typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_CAL} drc_hstate_t;
  drc_hstate_t       state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              range_r, range_nxt;
  drc_cmd_t          cmd_r, cmd_nxt;
  logic [7:0]        data_r, data_nxt;
  logic              err_r;

  // an update still on the link has not yet dropped levelValid
  wire logic canExit = link.levelValid && (cmd_r != CMD_MRS);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    range_nxt = range_r;
    cmd_nxt   = CMD_DES;
    data_nxt  = 8'h00;
    case (state_r)
      HS_IDLE: begin
        if (reqEnter) begin
          cmd_nxt   = CMD_MRS;
          data_nxt  = {1'b1, reqRange, 6'h00};
          range_nxt = reqRange;
          state_nxt = HS_WAIT;
          cnt_nxt   = CNT_W'(ENTRY_CYC);
        end
      end
      HS_WAIT: begin
        if (cnt_r <= 1) state_nxt = (link.calActive) ? HS_CAL : HS_IDLE;
      end
      HS_CAL: begin
        if (reqSet && reqCode < CODE_RSVD_MIN) begin
          cmd_nxt  = CMD_MRS;
          data_nxt = {1'b1, range_r, reqCode};
        end else if (reqExit && canExit) begin
          cmd_nxt   = CMD_MRS;
          data_nxt  = 8'h00;
          state_nxt = HS_WAIT;
          // two extra cycles, so the device is already seen idle when the wait ends
          cnt_nxt   = CNT_W'(EXIT_CYC + 2);
        end
      end
      default: state_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= HS_IDLE;
      cnt_r   <= '0;
      range_r <= 1'b0;
      cmd_r   <= CMD_DES;
      data_r  <= 8'h00;
      err_r   <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      range_r <= range_nxt;
      cmd_r   <= cmd_nxt;
      data_r  <= data_nxt;
      err_r   <= err_r | link.cmdError;                      // sticky until reset
    end
  end

  // pda mode restricts us to register writes, which this host already obeys
  assign link.cmd     = cmd_r;
  assign link.mrData  = data_r;
  assign link.pdaMode = reqPda;
  assign busy         = (state_r == HS_WAIT);
  assign sawError     = err_r;
endmodule : drc_host
`default_nettype wire

// File: tb/drc_link_assertions.sv
// Purpose: protocol checks on the calibration command link
// Assumes: host and device ends share sys_clk
// Notes:   watched ends use default waits of 15 cycles, so 2-cycle runs are safe
`timescale 1ns/1ps
`default_nettype none
module drc_link_assertions (
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire drc_pkg::drc_cmd_t cmd,
  input wire logic [7:0]        mrData,
  input wire logic              pdaMode,
  input wire logic              calActive,
  input wire logic              levelValid,
  input wire logic              cmdError
);
  import drc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic rangeR;
  wire  mrs      = cmd == CMD_MRS;
  wire  enterCmd = mrs && mrData[7] && !calActive;
  wire  updCmd   = mrs && mrData[7] && calActive;
  wire  exitCmd  = mrs && !mrData[7] && calActive;
  // range held from entry, updates must match it
  always_ff @(posedge sys_clk) begin
    if (reset) rangeR <= 1'b0;
    else if (enterCmd) rangeR <= mrData[6];
  end
  sequence desRun;
    (cmd == CMD_DES)[*2];
  endsequence
  sequence settleRun;
    (!levelValid)[*7] ##[1:23] levelValid;
  endsequence
  a_entry_sets_cal: assert property (enterCmd |=> calActive) else $error("entry did not start calibration");
  a_entry_wait_des: assert property (enterCmd |=> desRun) else $error("command inside entry wait");
  a_no_illegal_cmd: assert property (!cmdError) else $error("device flagged host command");
  a_update_range: assert property (updCmd |-> mrData[6] == rangeR) else $error("range changed on update");
  a_update_unsettles: assert property (updCmd |=> !levelValid) else $error("level valid right after update");
  a_settle_span: assert property ($fell(levelValid) |-> settleRun) else $error("settle time out of span");
  a_exit_settled: assert property (exitCmd |-> levelValid) else $error("exit before settle");
  a_exit_wait_des: assert property (exitCmd |=> desRun) else $error("command inside exit wait");
  a_exit_drops: assert property (exitCmd |-> ##[1:20] !calActive) else $error("calibration not left");
  a_pda_mrs_only: assert property (pdaMode && calActive |-> cmd inside {CMD_DES, CMD_MRS}) else $error("pda cmd");
endmodule : drc_link_assertions
`default_nettype wire

// File: tb/testbench.sv
// Purpose: bench for both calibration ends
// Assumes: second device has entry and exit waits of 4 cycles
// Notes:   second device faces a scripted faulty controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import drc_pkg::*;
  logic       sys_clk, reset, reqEnter, reqRange, reqSet, reqExit, busy, sawError, rangeSel, calMode;
  logic [5:0] reqCode;
  logic       clkEn, reqPda;
  logic [6:0] refSetting, refSetting2;
  logic [5:0] codes [2] = '{6'h31, 6'h00};
  int         nFail = 0, cmpCount = 0, cyc = 0;
  drc_link_if lnk();
  drc_link_if lnkB();
  drc_host i_drc_host (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
    .reqEnter(reqEnter), .reqRange(reqRange), .reqSet(reqSet), .reqCode(reqCode), .reqExit(reqExit),
    .reqPda(reqPda), .busy(busy), .sawError(sawError), .link(lnk.host));
  drc_device i_drc_device (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
    .link(lnk.dev), .refSetting(refSetting), .rangeSel(rangeSel), .calMode(calMode));
  drc_device #(.ENTRY_CYC(4), .EXIT_CYC(4)) i_drc_device_b (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
    .link(lnkB.dev), .refSetting(refSetting2), .rangeSel(), .calMode());
  drc_link_assertions i_drc_link_assertions (.sys_clk(sys_clk), .reset(reset), .cmd(lnk.cmd),
    .mrData(lnk.mrData), .pdaMode(lnk.pdaMode), .calActive(lnk.calActive), .levelValid(lnk.levelValid),
    .cmdError(lnk.cmdError));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle request pulse, then wait out host waits and settle
  task automatic req(input logic e, input logic s, input logic x, input logic [5:0] c);
    int n;
    @(posedge sys_clk);
    reqEnter <= e;
    reqSet <= s;
    reqExit <= x;
    reqCode <= c;
    @(posedge sys_clk);
    reqEnter <= 1'b0;
    reqSet <= 1'b0;
    reqExit <= 1'b0;
    n = 0;
    repeat (3) @(posedge sys_clk);
    while ((busy !== 1'b0 || lnk.levelValid !== 1'b1) && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk({6'h00, busy, lnk.levelValid}, 8'h01);
    repeat (2) @(posedge sys_clk);
  endtask : req
  // error flag is due in the cycle after the command
  task automatic send(input drc_cmd_t c, input logic [7:0] d, input logic e);
    @(posedge sys_clk);
    lnkB.cmd <= c;
    lnkB.mrData <= d;
    @(posedge sys_clk);
    lnkB.cmd <= CMD_DES;
    lnkB.mrData <= 8'h00;
    #1 chk({7'h00, lnkB.cmdError}, {7'h00, e});
  endtask : send
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, whole run is a few hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      tally_and_finish();
    end
  end
  initial begin
    reset = 1'b1;
    {reqEnter, reqRange, reqSet, reqExit, reqCode} = '0;
    {clkEn, reqPda} = 2'b10;
    lnkB.cmd = CMD_DES;
    lnkB.mrData = 8'h00;
    lnkB.pdaMode = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1 chk({1'b0, refSetting}, 8'h00);
    for (int r = 0; r < 2; r++) begin
      reqRange <= r[0];
      reqPda <= r[0];
      req(1'b1, 1'b0, 1'b0, 6'h00);
      chk({7'h00, lnk.calActive}, 8'h01);
      req(1'b0, 1'b1, 1'b0, codes[r]);
      req(1'b0, 1'b1, 1'b0, codes[r] + 6'h01);
      req(1'b0, 1'b0, 1'b1, 6'h00);
      chk({1'b0, refSetting}, {1'b0, r[0], codes[r] + 6'h01});
      chk({6'h00, rangeSel, calMode}, {6'h00, r[0], 1'b0});
      chk({7'h00, sawError}, 8'h00);
      $display("test host range %0d done", r);
    end
    send(CMD_MRS, 8'h45, 1'b0);
    chk({1'b0, refSetting2}, 8'h45);
    send(CMD_MRS, 8'h80, 1'b0);
    chk({7'h00, lnkB.calActive}, 8'h01);
    send(CMD_MRS, 8'h81, 1'b1);
    repeat (6) @(posedge sys_clk);
    send(CMD_WR, 8'h00, 1'b0);
    send(CMD_MRS, 8'hc5, 1'b1);
    send(CMD_MRS, 8'hb3, 1'b1);
    send(CMD_OTHER, 8'h00, 1'b1);
    send(CMD_MRS, 8'ha0, 1'b0);
    lnkB.pdaMode <= 1'b1;
    send(CMD_ACT, 8'h00, 1'b1);
    lnkB.pdaMode <= 1'b0;
    send(CMD_PRE, 8'h00, 1'b0);
    repeat (30) @(posedge sys_clk);
    send(CMD_MRS, 8'h7f, 1'b0);
    send(CMD_RD, 8'h00, 1'b1);
    chk({1'b0, refSetting2}, 8'h20);
    repeat (4) @(posedge sys_clk);
    send(CMD_MRS, 8'h80, 1'b0);
    repeat (6) @(posedge sys_clk);
    send(CMD_ACT, 8'h00, 1'b0);
    send(CMD_MRS, 8'h00, 1'b1);
    repeat (6) @(posedge sys_clk);
    chk({7'h00, lnkB.calActive}, 8'h00);
    send(CMD_PRE, 8'h00, 1'b0);
    send(CMD_MRS, 8'h80, 1'b0);
    repeat (6) @(posedge sys_clk);
    send(CMD_MRS, 8'h81, 1'b0);
    send(CMD_MRS, 8'h00, 1'b1);
    repeat (6) @(posedge sys_clk);
    chk({1'b0, refSetting2}, 8'h01);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    send(CMD_MRS, 8'h11, 1'b0);
    chk({1'b0, refSetting2}, 8'h01);
    clkEn <= 1'b1;
    send(CMD_MRS, 8'h11, 1'b0);
    chk({1'b0, refSetting2}, 8'h11);
    $display("test faulty controller done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
